// ### src/circ_pkg.sv
package circ_pkg;

    // ****************************************************************
    // register indices and byte addresses
    // ****************************************************************
    localparam int unsigned ADDR_W        = 12;
    localparam int unsigned IDX_M_EVEN    = 'h20;
    localparam int unsigned IDX_M_ODD     = 'h21;
    localparam int unsigned IDX_S_EVEN    = 'hA0;
    localparam int unsigned IDX_S_ODD     = 'hA1;
    localparam int unsigned IDX_EV_STATUS = 'hB0;
    localparam int unsigned IDX_EV_MASK   = 'hB1;
    localparam logic [ADDR_W-1:0] ADDR_M_EVEN    = ADDR_W'(IDX_M_EVEN * 4);
    localparam logic [ADDR_W-1:0] ADDR_M_ODD     = ADDR_W'(IDX_M_ODD * 4);
    localparam logic [ADDR_W-1:0] ADDR_S_EVEN    = ADDR_W'(IDX_S_EVEN * 4);
    localparam logic [ADDR_W-1:0] ADDR_S_ODD     = ADDR_W'(IDX_S_ODD * 4);
    localparam logic [ADDR_W-1:0] ADDR_EV_STATUS = ADDR_W'(IDX_EV_STATUS * 4);
    localparam logic [ADDR_W-1:0] ADDR_EV_MASK   = ADDR_W'(IDX_EV_MASK * 4);

    // ****************************************************************
    // field positions and codes
    // ****************************************************************
    localparam int unsigned INIT_SEL_BIT   = 4;
    localparam int unsigned INIT_IC4_BIT   = 0;
    localparam int unsigned CAS_SLAVE_BIT  = 2;
    localparam int unsigned MODE_SPECIAL_NESTED_SELECT_BIT  = 4;
    localparam int unsigned MODE_AUTO_END_OF_INTERRUPT_BIT  = 1;
    localparam int unsigned VEC_LEVEL_W    = 3;
    localparam logic [7:0]  EOI_NONSPEC    = 8'h20;
    localparam logic [2:0]  SLAVE_CODE     = 3'h2;
    localparam logic [2:0]  SLAVE_INPUT    = 3'h2;
    localparam logic [7:0]  MASK_RESET     = 8'h00;
    localparam int unsigned EV_W           = 3;
    localparam int unsigned EV_INT_RISE    = 0;
    localparam int unsigned EV_VECTOR      = 1;
    localparam int unsigned EV_SPURIOUS    = 2;

    typedef enum logic [1:0] {
        CIRC_WAIT_VECTOR,
        CIRC_WAIT_CASCADE,
        CIRC_WAIT_MODE,
        CIRC_READY
    } circ_init_t;

    // highest-priority set bit: {found, index}, bit 0 wins
    function automatic logic [3:0] circ_first(input logic [7:0] v);
        logic [3:0] r;
        r = 4'h0;
        for (int i = 7; i >= 0; i--) begin
            if (v[i]) begin
                r = {1'b1, 3'(i)};
            end
        end
        return r;
    endfunction

endpackage

// ### src/circ_ctrl.sv
`timescale 1ns/1ps
module circ_ctrl
    import circ_pkg::*;
(
    input  wire logic       clk,
    input  wire logic       rst_n,
    input  wire logic       wr_even,
    input  wire logic       wr_odd,
    input  wire logic [7:0] wdata,
    input  wire logic [7:0] req,
    input  wire logic       ack_take,
    input  wire logic       ack_done,
    output logic            int_out,
    output logic [7:0]      mask,
    output logic [7:0]      cascade,
    output logic [7:0]      vector,
    output logic [3:0]      top_req,
    output logic            init_ready
);

    // ****************************************************************
    // state
    // ****************************************************************
    circ_init_t  state;
    logic [7:0]  base;
    logic [7:0]  mode;
    logic [7:0]  isr;
    logic        need_mode;
    logic [2:0]  taken;
    logic [7:0]  next_isr;

    wire logic [7:0] accepted  = req & ~mask;
    wire logic [3:0] top_isr   = circ_first(isr);
    wire logic       special_nested_select      = mode[MODE_SPECIAL_NESTED_SELECT_BIT];
    wire logic       auto_end_of_interrupt      = mode[MODE_AUTO_END_OF_INTERRUPT_BIT];
    wire logic       init_wr   = wr_even & wdata[INIT_SEL_BIT];
    wire logic       eoi_wr    = wr_even & (wdata == EOI_NONSPEC);
    wire logic       pending   = top_req[3] & (~top_isr[3] | (top_req[2:0] < top_isr[2:0])
                                 | (special_nested_select & (top_req[2:0] == top_isr[2:0])));

    assign top_req    = circ_first(accepted);
    assign vector     = {base[7:VEC_LEVEL_W], taken};
    assign init_ready = (state == CIRC_READY);

    always_comb begin
        next_isr = isr;
        if (ack_take && top_req[3]) begin
            next_isr[top_req[2:0]] = 1'b1;
        end
        if (ack_done && auto_end_of_interrupt) begin
            next_isr[taken] = 1'b0;
        end
        if (eoi_wr && top_isr[3]) begin
            next_isr[top_isr[2:0]] = 1'b0;
        end
    end

    // ****************************************************************
    // init sequence and mask
    // ****************************************************************
    always_ff @(posedge clk) begin
        if (!rst_n) begin
            state     <= CIRC_READY;
            mask      <= MASK_RESET;
            base      <= 8'h00;
            cascade   <= 8'h00;
            mode      <= 8'h00;
            need_mode <= 1'b0;
        end else if (init_wr) begin
            mask      <= MASK_RESET;
            state     <= CIRC_WAIT_VECTOR;
            need_mode <= wdata[INIT_IC4_BIT];
        end else if (wr_odd) begin
            unique case (state)
                CIRC_WAIT_VECTOR: begin
                    base  <= wdata;
                    state <= CIRC_WAIT_CASCADE;
                end
                CIRC_WAIT_CASCADE: begin
                    cascade <= wdata;
                    mode    <= 8'h00;
                    state   <= need_mode ? CIRC_WAIT_MODE : CIRC_READY;
                end
                CIRC_WAIT_MODE: begin
                    mode  <= wdata;
                    state <= CIRC_READY;
                end
                CIRC_READY: begin
                    mask <= wdata;
                end
            endcase
        end
    end

    always_ff @(posedge clk) begin
        if (!rst_n) begin
            isr     <= 8'h00;
            taken   <= 3'h0;
            int_out <= 1'b0;
        end else begin
            isr     <= next_isr;
            int_out <= pending;
            if (ack_take) begin
                taken <= top_req[2:0];
            end
        end
    end

    a_init_order: assert property (@(posedge clk) disable iff (!rst_n)
        (state == CIRC_WAIT_VECTOR && wr_odd && !init_wr) |=> (state == CIRC_WAIT_CASCADE && base == $past(wdata)))
        else $error("vector base word not taken in order");

    a_auto_end_of_interrupt_clear: assert property (@(posedge clk) disable iff (!rst_n)
        (ack_done && auto_end_of_interrupt && !ack_take) |=> !isr[$past(taken)])
        else $error("auto end of interrupt left in-service bit set");

endmodule // circ_ctrl

// ### src/circ_top.sv
// Summary of operation
// - init word starts vector, cascade, mode sequence
// - init word clears request mask
// - slave arbitrates high lines, drives master input 2
// - master arbitrates input 2, raises processor request
// - slave compares id with broadcast code
// - matching slave supplies the vector
// - mode bit 4 selects special nesting
// - mode bit 1 selects automatic end
// - mask bit one blocks its request
// - mask bit zero accepts requests again
// - masking master input 2 blocks slave
`timescale 1ns/1ps
module circ_top
    import circ_pkg::*;
(
    input  wire logic              clk,
    input  wire logic              rst_n,
    input  wire logic [ADDR_W-1:0] paddr,
    input  wire logic              psel,
    input  wire logic              penable,
    input  wire logic              pwrite,
    input  wire logic [31:0]       pwdata,
    output logic [31:0]            prdata,
    output logic                   pready,
    output logic                   pslverr,
    input  wire logic [15:0]       irq_in,
    input  wire logic              int_ack_strobe_n,
    output logic                   int_request_out,
    output logic [7:0]             vector_data,
    output logic                   vector_valid,
    output logic                   irq_out
);

    // ****************************************************************
    // bus decode
    // ****************************************************************
    wire logic setup     = psel & ~penable;
    wire logic access    = psel & penable & pready;
    wire logic hit_m_ev  = (paddr == ADDR_M_EVEN);
    wire logic hit_m_od  = (paddr == ADDR_M_ODD);
    wire logic hit_s_ev  = (paddr == ADDR_S_EVEN);
    wire logic hit_s_od  = (paddr == ADDR_S_ODD);
    wire logic hit_st    = (paddr == ADDR_EV_STATUS);
    wire logic hit_mk    = (paddr == ADDR_EV_MASK);
    wire logic hit_any   = hit_m_ev | hit_m_od | hit_s_ev | hit_s_od | hit_st | hit_mk;
    wire logic wr_acc    = access & pwrite & hit_any;
    wire logic wr_m_even = wr_acc & hit_m_ev;
    wire logic wr_m_odd  = wr_acc & hit_m_od;
    wire logic wr_s_even = wr_acc & hit_s_ev;
    wire logic wr_s_odd  = wr_acc & hit_s_od;
    wire logic wr_ev_mk  = wr_acc & hit_mk;
    wire logic rd_st     = access & ~pwrite & hit_st;

    // ****************************************************************
    // pin synchronisers
    // ****************************************************************
    logic [15:0] irq_s1;
    logic [15:0] irq_s2;
    logic        ack_s1;
    logic        ack_s2;
    logic        ack_d;
    logic        ack_second;

    always_ff @(posedge clk) begin
        if (!rst_n) begin
            irq_s1 <= 16'h0000;
            irq_s2 <= 16'h0000;
            ack_s1 <= 1'b1;
            ack_s2 <= 1'b1;
            ack_d  <= 1'b1;
        end else begin
            irq_s1 <= irq_in;
            irq_s2 <= irq_s1;
            ack_s1 <= int_ack_strobe_n;
            ack_s2 <= ack_s1;
            ack_d  <= ack_s2;
        end
    end

    // trailing edge of each acknowledge pulse
    wire logic ack_end   = ack_s2 & ~ack_d;
    wire logic first_end = ack_end & ~ack_second;
    wire logic last_end  = ack_end & ack_second;

    // ****************************************************************
    // controller pair
    // ****************************************************************
    logic       m_int;
    logic [7:0] m_mask;
    logic [7:0] m_cas;
    logic [7:0] m_vec;
    logic [3:0] m_top;
    logic       m_ready;
    logic       s_int;
    logic [7:0] s_mask;
    logic [7:0] s_cas;
    logic [7:0] s_vec;
    logic [3:0] s_top;
    logic       s_ready;
    logic       slave_sel;

    wire logic [7:0] m_req = {irq_s2[7:3], s_int, irq_s2[1:0]};
    wire logic [7:0] s_req = irq_s2[15:8];

    // code the master broadcasts between the two pulses
    wire logic [2:0] cas_code   = m_top[2:0];
    wire logic       cas_active = m_top[3] & (m_top[2:0] == SLAVE_INPUT) & m_cas[CAS_SLAVE_BIT];
    wire logic       s_match    = cas_active & (s_cas[2:0] == cas_code);
    wire logic       spurious   = first_end & ~m_top[3];

    circ_ctrl u_master (
        .clk        (clk),
        .rst_n      (rst_n),
        .wr_even    (wr_m_even),
        .wr_odd     (wr_m_odd),
        .wdata      (pwdata[7:0]),
        .req        (m_req),
        .ack_take   (first_end),
        .ack_done   (last_end),
        .int_out    (m_int),
        .mask       (m_mask),
        .cascade    (m_cas),
        .vector     (m_vec),
        .top_req    (m_top),
        .init_ready (m_ready)
    );

    circ_ctrl u_slave (
        .clk        (clk),
        .rst_n      (rst_n),
        .wr_even    (wr_s_even),
        .wr_odd     (wr_s_odd),
        .wdata      (pwdata[7:0]),
        .req        (s_req),
        .ack_take   (first_end & s_match),
        .ack_done   (last_end & slave_sel),
        .int_out    (s_int),
        .mask       (s_mask),
        .cascade    (s_cas),
        .vector     (s_vec),
        .top_req    (s_top),
        .init_ready (s_ready)
    );

    // ****************************************************************
    // acknowledge sequence
    // ****************************************************************
    wire logic [7:0] next_vector = slave_sel ? s_vec : m_vec;

    always_ff @(posedge clk) begin
        if (!rst_n) begin
            ack_second      <= 1'b0;
            slave_sel       <= 1'b0;
            vector_data     <= 8'h00;
            vector_valid    <= 1'b0;
            int_request_out <= 1'b0;
        end else begin
            int_request_out <= m_int;
            vector_valid    <= last_end;
            if (first_end) begin
                ack_second <= 1'b1;
                slave_sel  <= s_match;
            end else if (last_end) begin
                ack_second  <= 1'b0;
                vector_data <= next_vector;
            end
        end
    end

    // ****************************************************************
    // event status and interrupt
    // ****************************************************************
    logic [EV_W-1:0] ev_status;
    logic [EV_W-1:0] ev_mask;
    logic            m_int_d;
    logic [EV_W-1:0] ev_set;
    logic [EV_W-1:0] next_status;

    always_comb begin
        ev_set              = '0;
        ev_set[EV_INT_RISE] = m_int & ~m_int_d;
        ev_set[EV_VECTOR]   = last_end;
        ev_set[EV_SPURIOUS] = spurious;
    end

    // only bits already reported are cleared; a set in the clearing cycle survives
    assign next_status = (rd_st ? (ev_status & ~prdata[EV_W-1:0]) : ev_status) | ev_set;

    always_ff @(posedge clk) begin
        if (!rst_n) begin
            ev_status <= '0;
            ev_mask   <= '0;
            m_int_d   <= 1'b0;
            irq_out   <= 1'b0;
        end else begin
            ev_status <= next_status;
            m_int_d   <= m_int;
            irq_out   <= |(next_status & ev_mask);
            if (wr_ev_mk) begin
                ev_mask <= pwdata[EV_W-1:0];
            end
        end
    end

    // ****************************************************************
    // read path
    // ****************************************************************
    wire logic [7:0] m_irr_rd = m_req;
    wire logic [7:0] s_irr_rd = s_req;
    logic [31:0]     rd_mux;

    always_comb begin
        rd_mux = 32'h0000_0000;
        if (hit_m_ev) begin
            rd_mux[7:0] = m_irr_rd;
        end else if (hit_m_od) begin
            rd_mux[7:0] = m_mask;
        end else if (hit_s_ev) begin
            rd_mux[7:0] = s_irr_rd;
        end else if (hit_s_od) begin
            rd_mux[7:0] = s_mask;
        end else if (hit_st) begin
            rd_mux[EV_W-1:0] = ev_status;
        end else if (hit_mk) begin
            rd_mux[EV_W-1:0] = ev_mask;
        end
    end

    always_ff @(posedge clk) begin
        if (!rst_n) begin
            prdata  <= 32'h0000_0000;
            pready  <= 1'b0;
            pslverr <= 1'b0;
        end else begin
            pready <= 1'b1;
            if (setup) begin
                prdata  <= rd_mux;
                pslverr <= ~hit_any;
            end
        end
    end

    // ****************************************************************
    // checks
    // ****************************************************************
    a_mask_init_clr: assert property (@(posedge clk) disable iff (!rst_n)
        (wr_m_even && pwdata[INIT_SEL_BIT]) |=> (m_mask == MASK_RESET))
        else $error("init word did not clear master mask");

    a_mask_write: assert property (@(posedge clk) disable iff (!rst_n)
        (wr_m_odd && m_ready) |=> (m_mask == $past(pwdata[7:0])))
        else $error("mask write after init not stored");

    a_mask_blocks: assert property (@(posedge clk) disable iff (!rst_n)
        (m_mask == 8'hFF) [*3] |=> !m_int)
        else $error("fully masked controller raised request");

    a_slave_block: assert property (@(posedge clk) disable iff (!rst_n)
        (m_mask[SLAVE_INPUT] && m_top[3]) |-> (m_top[2:0] != SLAVE_INPUT))
        else $error("masked cascade input still won arbitration");

    a_cascade_feed: assert property (@(posedge clk) disable iff (!rst_n)
        $rose(s_int) && !m_mask[SLAVE_INPUT] |-> m_req[SLAVE_INPUT])
        else $error("slave request did not reach master input");

    a_int_follow: assert property (@(posedge clk) disable iff (!rst_n)
        $rose(m_int) |=> int_request_out)
        else $error("processor request did not follow master");

    a_slave_sel: assert property (@(posedge clk) disable iff (!rst_n)
        first_end |=> (slave_sel == $past(s_match)))
        else $error("slave id compare not latched at first pulse end");

    a_vector_src: assert property (@(posedge clk) disable iff (!rst_n)
        (last_end && slave_sel) |=> (vector_data == $past(s_vec)) && vector_valid)
        else $error("matching slave did not supply vector");

    a_status_keep: assert property (@(posedge clk) disable iff (!rst_n)
        (rd_st && last_end) |=> ev_status[EV_VECTOR])
        else $error("event lost in clearing read");

    a_pready_zero: assert property (@(posedge clk) disable iff (!rst_n)
        (psel && !penable) |=> pready)
        else $error("access phase entered with wait state");

    a_slverr_map: assert property (@(posedge clk) disable iff (!rst_n)
        (psel && !penable) |=> (pslverr == !$past(hit_any)))
        else $error("error response does not match decode");

    a_slave_init_clr: assert property (@(posedge clk) disable iff (!rst_n)
        (wr_s_even && pwdata[INIT_SEL_BIT]) |=> (s_mask == MASK_RESET))
        else $error("init word did not clear slave mask");

    a_slave_mask_wr: assert property (@(posedge clk) disable iff (!rst_n)
        (wr_s_odd && s_ready) |=> (s_mask == $past(pwdata[7:0])))
        else $error("slave mask write after init not stored");

    a_master_vec: assert property (@(posedge clk) disable iff (!rst_n)
        (last_end && !slave_sel) |=> (vector_data == $past(m_vec)) && vector_valid)
        else $error("master vector not delivered");

    a_id_mismatch: assert property (@(posedge clk) disable iff (!rst_n)
        (first_end && (s_cas[2:0] != SLAVE_CODE)) |=> !slave_sel)
        else $error("slave selected with wrong id");

    a_cascade_sel: assert property (@(posedge clk) disable iff (!rst_n)
        (first_end && m_top[3] && (m_top[2:0] == SLAVE_INPUT) && m_cas[CAS_SLAVE_BIT]
         && (s_cas[2:0] == SLAVE_CODE)) |=> slave_sel)
        else $error("slave not selected for cascade code");

    a_master_idle: assert property (@(posedge clk) disable iff (!rst_n)
        ((m_req & ~m_mask) == 8'h00) |=> !m_int)
        else $error("master request with all lines masked");

    a_slave_idle: assert property (@(posedge clk) disable iff (!rst_n)
        ((s_req & ~s_mask) == 8'h00) |=> !s_int)
        else $error("slave request with all lines masked");

    a_valid_pulse: assert property (@(posedge clk) disable iff (!rst_n)
        vector_valid |=> !vector_valid)
        else $error("vector valid longer than one cycle");

    a_vector_hold: assert property (@(posedge clk) disable iff (!rst_n)
        !$past(last_end) |-> $stable(vector_data))
        else $error("vector data changed without acknowledge");

    a_irq_level: assert property (@(posedge clk) disable iff (!rst_n)
        !$past(wr_ev_mk) |-> (irq_out == |(ev_status & ev_mask)))
        else $error("interrupt output does not follow status");

    a_spur_event: assert property (@(posedge clk) disable iff (!rst_n)
        spurious |=> ev_status[EV_SPURIOUS])
        else $error("spurious acknowledge not recorded");

    a_rise_event: assert property (@(posedge clk) disable iff (!rst_n)
        (m_int && !m_int_d) |=> ev_status[EV_INT_RISE])
        else $error("request rise not recorded");

endmodule // circ_top

// ### tb/circ_cpu_model.sv
`timescale 1ns/1ps
module circ_cpu_model (
    input  wire logic       clk,
    input  wire logic       go,
    input  wire logic       slow,
    input  wire logic [7:0] vector_data,
    input  wire logic       vector_valid,
    output logic            int_ack_strobe_n,
    output logic [7:0]      vec,
    output logic            seen,
    output logic            done
);
    int n;

    // ****************************************************************
    // two acknowledge pulses, n clocks low and n clocks high each
    // ****************************************************************
    initial begin
        int_ack_strobe_n = 1'b1;
        done = 1'b0;
        forever begin
            @(posedge clk);
            if (go) begin
                done <= 1'b0;
                n = slow ? 5 : 2;
                repeat (2) begin
                    int_ack_strobe_n <= 1'b0;
                    repeat (n) @(posedge clk);
                    int_ack_strobe_n <= 1'b1;
                    repeat (n) @(posedge clk);
                end
                repeat (8) @(posedge clk);
                done <= 1'b1;
            end
        end
    end

    // keep the vector of the current acknowledge only
    always @(posedge clk) begin
        if (go) begin
            seen <= 1'b0;
        end else if (vector_valid) begin
            seen <= 1'b1;
            vec  <= vector_data;
        end
    end
endmodule // circ_cpu_model

// ### tb/tb_cascaded_irq_ctrl_init_mask.sv
`timescale 1ns/1ps
module tb_cascaded_irq_ctrl_init_mask import circ_pkg::*;;
    typedef struct packed {
        logic [15:0] irq;
        logic [7:0]  mm;
        logic [7:0]  sm;
        logic        ireq;
        logic [7:0]  vec;
    } circ_row_t;

    logic              clk;
    logic              rst_n;
    logic [ADDR_W-1:0] paddr;
    logic              psel;
    logic              penable;
    logic              pwrite;
    logic [31:0]       pwdata;
    logic [31:0]       prdata;
    logic              pready;
    logic              pslverr;
    logic [15:0]       irq_in;
    logic              int_ack_strobe_n;
    logic              int_request_out;
    logic [7:0]        vector_data;
    logic              vector_valid;
    logic              irq_out;
    logic              go;
    logic              slow;
    logic [7:0]        vec;
    logic              seen;
    logic              done;
    logic [31:0]       rdat;
    logic              rerr;
    int                error_cnt;
    int                comparisons;
    circ_row_t         rows [8] = '{
        '{16'h0008, 8'h00, 8'h00, 1'b1, 8'h0B},
        '{16'h0008, 8'hFF, 8'h00, 1'b0, 8'h00},
        '{16'h0200, 8'h00, 8'h00, 1'b1, 8'h71},
        '{16'h0200, 8'h04, 8'h00, 1'b0, 8'h00},
        '{16'h0200, 8'h00, 8'h02, 1'b0, 8'h00},
        '{16'h0209, 8'h00, 8'h00, 1'b1, 8'h08},
        '{16'h8000, 8'h00, 8'h00, 1'b1, 8'h77},
        '{16'h0200, 8'hFB, 8'h00, 1'b1, 8'h71}
    };

    circ_top DUT (
        .clk(clk), .rst_n(rst_n), .paddr(paddr), .psel(psel), .penable(penable), .pwrite(pwrite),
        .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr), .irq_in(irq_in),
        .int_ack_strobe_n(int_ack_strobe_n), .int_request_out(int_request_out),
        .vector_data(vector_data), .vector_valid(vector_valid), .irq_out(irq_out)
    );

    circ_cpu_model cpu (
        .clk(clk), .go(go), .slow(slow), .vector_data(vector_data), .vector_valid(vector_valid),
        .int_ack_strobe_n(int_ack_strobe_n), .vec(vec), .seen(seen), .done(done)
    );

    // ****************************************************************
    // bus, acknowledge and check tasks
    // ****************************************************************
    task automatic complete_run;
        $display("Comparisons %0d, errors %0d", comparisons, error_cnt);
        if (error_cnt == 0 && comparisons > 0) begin
            $display("Simulation passed");
        end else begin
            $display("Simulation failed");
        end
        $finish;
    endtask

    task automatic chk(input logic [31:0] g, input logic [31:0] e);
        comparisons++;
        if (g !== e) begin
            error_cnt++;
            $display("Error at %0t: got %h expected %h", $time, g, e);
        end
    endtask

    task automatic hang;
        error_cnt++;
        $display("Error at %0t: wait limit reached", $time);
        complete_run();
    endtask

    task automatic apb(input logic [ADDR_W-1:0] a, input logic w, input logic [7:0] d);
        int k;
        paddr   <= a;
        pwrite  <= w;
        pwdata  <= {24'h0, d};
        psel    <= 1'b1;
        penable <= 1'b0;
        @(posedge clk);
        penable <= 1'b1;
        k = 0;
        do begin
            @(posedge clk);
            k++;
        end while (!pready && k < 10);
        if (!pready) hang();
        rdat = prdata;
        rerr = pslverr;
        psel    <= 1'b0;
        penable <= 1'b0;
        @(posedge clk);
    endtask

    task automatic do_ack(input logic sl);
        int k;
        go   <= 1'b1;
        slow <= sl;
        @(posedge clk);
        go <= 1'b0;
        k = 0;
        do begin
            @(posedge clk);
            k++;
        end while (!done && k < 80);
        if (!done) hang();
    endtask

    task automatic eoi;
        apb(ADDR_S_EVEN, 1'b1, EOI_NONSPEC);
        apb(ADDR_M_EVEN, 1'b1, EOI_NONSPEC);
    endtask

    task automatic init_ctrl(input logic slv, input logic [7:0] base, cas, mode);
        logic [ADDR_W-1:0] ev;
        logic [ADDR_W-1:0] od;
        ev = slv ? ADDR_S_EVEN : ADDR_M_EVEN;
        od = slv ? ADDR_S_ODD : ADDR_M_ODD;
        apb(od, 1'b1, 8'h5A);
        apb(od, 1'b0, 8'h00);
        chk(rdat, 32'h5A);
        apb(ev, 1'b1, 8'h11);
        apb(od, 1'b1, base);
        apb(od, 1'b1, cas);
        apb(od, 1'b1, mode);
        apb(od, 1'b0, 8'h00);
        chk(rdat, 32'h0);
    endtask

    task automatic seq(input logic [7:0] mode, input logic [15:0] a, b, input logic [7:0] v, input logic e);
        init_ctrl(1'b0, 8'h08, 8'h04, mode);
        irq_in <= a;
        repeat (8) @(posedge clk);
        do_ack(1'b0);
        chk({23'h0, seen, vec}, {24'h1, v});
        irq_in <= b;
        repeat (8) @(posedge clk);
        chk({31'h0, int_request_out}, {31'h0, e});
        irq_in <= 16'h0;
        eoi();
    endtask

    initial begin
        clk = 1'b0;
        forever #50 clk = ~clk;
    end

    // ****************************************************************
    // main sequence
    // ****************************************************************
    initial begin
        rst_n = 1'b0; paddr = '0; psel = 1'b0; penable = 1'b0; pwrite = 1'b0;
        pwdata = 32'h0; irq_in = 16'h0; go = 1'b0; slow = 1'b0;
        error_cnt = 0; comparisons = 0;
        repeat (5) @(posedge clk);
        rst_n <= 1'b1;
        @(posedge clk);
        apb(ADDR_M_ODD, 1'b0, 8'h00);
        chk(rdat, {24'h0, MASK_RESET});
        apb(12'h3FC, 1'b0, 8'h00);
        chk({rerr, rdat[30:0]}, 32'h80000000);
        init_ctrl(1'b0, 8'h08, 8'h04, 8'h01);
        init_ctrl(1'b1, 8'h70, 8'h02, 8'h01);
        for (int i = 0; i < 8; i++) begin
            apb(ADDR_M_ODD, 1'b1, rows[i].mm);
            apb(ADDR_S_ODD, 1'b1, rows[i].sm);
            apb(ADDR_M_ODD, 1'b0, 8'h00);
            chk(rdat, {24'h0, rows[i].mm});
            irq_in <= rows[i].irq;
            repeat (8) @(posedge clk);
            chk({31'h0, int_request_out}, {31'h0, rows[i].ireq});
            if (rows[i].ireq) begin
                do_ack(i[0]);
                chk({23'h0, seen, vec}, {24'h1, rows[i].vec});
            end
            irq_in <= 16'h0;
            eoi();
        end
        chk({31'h0, irq_out}, 32'h0);
        apb(ADDR_EV_MASK, 1'b1, 8'h07);
        repeat (3) @(posedge clk);
        chk({31'h0, irq_out}, 32'h1);
        apb(ADDR_EV_STATUS, 1'b0, 8'h00);
        chk(rdat, 32'h3);
        repeat (3) @(posedge clk);
        chk({31'h0, irq_out}, 32'h0);
        seq(8'h01, 16'h0008, 16'h0008, 8'h0B, 1'b0);
        seq(8'h03, 16'h0008, 16'h0008, 8'h0B, 1'b1);
        seq(8'h01, 16'h0200, 16'h0300, 8'h71, 1'b0);
        seq(8'h11, 16'h0200, 16'h0300, 8'h71, 1'b1);
        apb(ADDR_EV_STATUS, 1'b0, 8'h00);
        do_ack(1'b1);
        repeat (3) @(posedge clk);
        chk({31'h0, irq_out}, 32'h1);
        apb(ADDR_EV_STATUS, 1'b0, 8'h00);
        chk(rdat & 32'h4, 32'h4);
        apb(ADDR_M_ODD, 1'b1, 8'hFF);
        rst_n <= 1'b0;
        repeat (2) @(posedge clk);
        rst_n <= 1'b1;
        @(posedge clk);
        apb(ADDR_M_ODD, 1'b0, 8'h00);
        chk(rdat, {24'h0, MASK_RESET});
        chk({31'h0, irq_out}, 32'h0);
        complete_run();
    end
endmodule // tb_cascaded_irq_ctrl_init_mask
